/* rtl/adc_window_detector.sv */
`timescale 1ns/1ps
module adc_window_detector
	import window_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic              result_valid,        // one-cycle pulse: new conversion result
	input  wire logic [DATA_W-1:0] conversion_result,   // result word, stable while result_valid
	input  wire logic              differential_mode,   // 1: signed compare, 0: unsigned
	input  wire logic              lower_limit_we,      // write strobe for lower limit
	input  wire logic              upper_limit_we,      // write strobe for upper limit
	input  wire logic [DATA_W-1:0] limit_wdata,         // write data for the limits
	input  wire logic              flag_clear,          // one-cycle pulse: clear the match flag
	input  wire logic              irq_enable,          // interrupt enable level
	output logic [DATA_W-1:0]      window_lower_limit,  // lower limit readback
	output logic [DATA_W-1:0]      window_upper_limit,  // upper limit readback
	output logic                   window_match_flag,   // sticky match flag
	output logic                   irq                  // interrupt request
);
	// stored limits, flag and the order-mapped compare terms
	logic [DATA_W-1:0] lower_q;     // lower limit register
	logic [DATA_W-1:0] upper_q;     // upper limit register
	logic              flag_q;      // sticky flag
	logic [DATA_W-1:0] res_m;       // result mapped to unsigned order
	logic [DATA_W-1:0] low_m;       // lower mapped
	logic [DATA_W-1:0] up_m;        // upper mapped
	logic              match;       // window condition holds

	// limit registers written by software
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			// equal zero limits: any nonzero result matches
			lower_q <= LIMIT_RST;
			upper_q <= LIMIT_RST;
		end else begin
			if (lower_limit_we) begin
				lower_q <= limit_wdata;
			end
			if (upper_limit_we) begin
				upper_q <= limit_wdata;
			end
		end
	end

	// flipping the sign bit turns signed order into unsigned order
	always_comb begin
		if (differential_mode) begin
			// signed: sign bit flipped on all three words
			res_m = conversion_result ^ SIGN_FLIP;
			low_m = lower_q ^ SIGN_FLIP;
			up_m  = upper_q ^ SIGN_FLIP;
		end else begin
			// unsigned: words used as they stand
			res_m = conversion_result;
			low_m = lower_q;
			up_m  = upper_q;
		end
	end

	// inside or outside chosen by limit order alone
	// the compare runs every cycle; only a result_valid edge acts on it,
	// with the limits that stand at that edge
	always_comb begin
		if (up_m > low_m) begin
			// upper above lower: strictly between both limits
			match = (res_m > low_m) && (res_m < up_m);
		end else begin
			// reversed or equal limits: below upper or above lower
			match = (res_m < up_m) || (res_m > low_m);
		end
	end

	// sticky flag; a new match wins over a clear
	// a clear that meets a matching result is lost, so software re-reads the flag
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flag_q <= 1'b0;
		end else if (result_valid && match) begin
			flag_q <= 1'b1;
		// a clear acts only on a cycle without a new match
		end else if (flag_clear) begin
			flag_q <= 1'b0;
		end
	end

	// readbacks come straight from registers; the request is the flag gated by irq_enable
	assign window_lower_limit = lower_q;
	assign window_upper_limit = upper_q;
	assign window_match_flag  = flag_q;
	assign irq                = flag_q & irq_enable;

	// checks on the block's own outputs and compare terms, on the system clock,
	// all held off while reset is low
	// a taken result inside the selected window must set the flag
	property p_set;
		@(posedge sys_clk) disable iff (!rstn) (result_valid && match) |=> window_match_flag;
	endproperty
	a_set: assert property (p_set) else $error("match did not set flag");

	// the flag holds until software clears it
	property p_hold;
		@(posedge sys_clk) disable iff (!rstn) (window_match_flag && !flag_clear) |=> window_match_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped without clear");

	// without a matching result the flag stays low
	property p_noset;
		@(posedge sys_clk) disable iff (!rstn)
			(!window_match_flag && !(result_valid && match)) |=> !window_match_flag;
	endproperty
	a_noset: assert property (p_noset) else $error("flag set without match");

	// unsigned inside form against the limits as stored
	property p_inside;
		@(posedge sys_clk) disable iff (!rstn)
			(!differential_mode && upper_q > lower_q) |->
			(match == (conversion_result > lower_q && conversion_result < upper_q));
	endproperty
	a_inside: assert property (p_inside) else $error("inside compare wrong");

	// unsigned outside form, equal limits included
	property p_outside;
		@(posedge sys_clk) disable iff (!rstn)
			(!differential_mode && upper_q <= lower_q) |->
			(match == (conversion_result < upper_q || conversion_result > lower_q));
	endproperty
	a_outside: assert property (p_outside) else $error("outside compare wrong");

	// signed window from minus one to sixteen takes zero to fifteen
	property p_signed;
		@(posedge sys_clk) disable iff (!rstn)
			(differential_mode && lower_q == 8'hFF && upper_q == 8'h10) |->
			(match == (conversion_result < 8'h10));
	endproperty
	a_signed: assert property (p_signed) else $error("signed window wrong");

	// request follows the flag only while enabled
	property p_irq;
		@(posedge sys_clk) disable iff (!rstn) irq == (window_match_flag && irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("irq not gated by flag");

	// a lower limit write lands one cycle later
	property p_write;
		@(posedge sys_clk) disable iff (!rstn) lower_limit_we |=> window_lower_limit == $past(limit_wdata);
	endproperty
	a_write: assert property (p_write) else $error("lower limit not written");

	// an upper limit write lands one cycle later
	property p_write_up;
		@(posedge sys_clk) disable iff (!rstn) upper_limit_we |=> window_upper_limit == $past(limit_wdata);
	endproperty
	a_write_up: assert property (p_write_up) else $error("upper limit not written");

	// both strobes together load the same byte into both limits
	property p_write_both;
		@(posedge sys_clk) disable iff (!rstn)
			(lower_limit_we && upper_limit_we) |=> (window_lower_limit == window_upper_limit);
	endproperty
	a_write_both: assert property (p_write_both) else $error("joint write differs");

	// without a strobe the lower limit keeps its value
	property p_keep_low;
		@(posedge sys_clk) disable iff (!rstn) !lower_limit_we |=> $stable(window_lower_limit);
	endproperty
	a_keep_low: assert property (p_keep_low) else $error("lower limit changed unwritten");

	// without a strobe the upper limit keeps its value
	property p_keep_up;
		@(posedge sys_clk) disable iff (!rstn) !upper_limit_we |=> $stable(window_upper_limit);
	endproperty
	a_keep_up: assert property (p_keep_up) else $error("upper limit changed unwritten");

	// a clear with no matching result drops the flag
	property p_clear;
		@(posedge sys_clk) disable iff (!rstn)
			(flag_clear && !(result_valid && match)) |=> !window_match_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not drop flag");

	// a match and a clear in one cycle leave the flag set
	property p_set_wins;
		@(posedge sys_clk) disable iff (!rstn)
			(flag_clear && result_valid && match) |=> window_match_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a new match");

	// the flag rises only after a taken, matching result
	property p_rise;
		@(posedge sys_clk) disable iff (!rstn) $rose(window_match_flag) |-> $past(result_valid && match);
	endproperty
	a_rise: assert property (p_rise) else $error("flag rose without match");

	// the flag falls only after a clear
	property p_fall;
		@(posedge sys_clk) disable iff (!rstn) $fell(window_match_flag) |-> $past(flag_clear);
	endproperty
	a_fall: assert property (p_fall) else $error("flag fell without clear");

	// signed inside form against the limits as stored
	property p_sinside;
		@(posedge sys_clk) disable iff (!rstn)
			(differential_mode && ($signed(upper_q) > $signed(lower_q))) |->
			(match == (($signed(conversion_result) > $signed(lower_q)) &&
			           ($signed(conversion_result) < $signed(upper_q))));
	endproperty
	a_sinside: assert property (p_sinside) else $error("signed inside compare wrong");

	// signed outside form, equal limits included
	property p_soutside;
		@(posedge sys_clk) disable iff (!rstn)
			(differential_mode && ($signed(upper_q) <= $signed(lower_q))) |->
			(match == (($signed(conversion_result) < $signed(upper_q)) ||
			           ($signed(conversion_result) > $signed(lower_q))));
	endproperty
	a_soutside: assert property (p_soutside) else $error("signed outside compare wrong");

	// equal limits: every result but the limit itself matches, in either mode
	property p_equal;
		@(posedge sys_clk) disable iff (!rstn)
			(upper_q == lower_q) |-> (match == (conversion_result != lower_q));
	endproperty
	a_equal: assert property (p_equal) else $error("equal limits compare wrong");
endmodule

/* pkg/window_pkg.sv */
// Operation
// - compare every new result automatically
// - match flag readable directly by software
// - two writable limit bytes, lower and upper
// - limit ordering selects inside or outside
// - upper above lower: strictly between sets flag
// - otherwise: below smaller or above larger
// - single-ended mode compares unsigned
// - differential mode compares two's complement
// - lower 0xFF acts as minus one in differential mode
package window_pkg;
	localparam int          DATA_W          = 8;            // result and limit width
	localparam logic [7:0]  LIMIT_RST       = 8'h00;        // reset value of both limits
	localparam logic [7:0]  SIGN_FLIP       = 8'h80;        // xor mask mapping signed onto unsigned order
endpackage

/* bench/conv_model.sv */
`timescale 1ns/1ps
// converter result source: one-cycle valid pulse, then the word is scrambled
module conv_model
	import window_pkg::*;
(
	input  wire logic              sys_clk,
	output logic                   result_valid,
	output logic [DATA_W-1:0]      conversion_result
);
	initial begin
		result_valid = 1'b0;
		conversion_result = 8'h00;
	end
	// present one word for one edge, then show its inverse so stale data never equals the taken word
	task convert(input logic [DATA_W-1:0] r);
		conversion_result = r;
		result_valid = 1'b1;
		@(posedge sys_clk);
		#1 result_valid = 1'b0;
		conversion_result = ~r;
	endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("wrong value %0t %h %h", $time, a, b); end end
module tb;
	import window_pkg::*;
	logic        sys_clk = 0, rstn = 0, rv, dm = 0, lwe = 0, uwe = 0, clr = 0, en = 0, e = 0;
	logic [7:0]  res, wd = 8'h00, lo_o, hi_o, l, h, r;
	logic        flag, irq;
	int          error_cnt = 0, checks = 0, k;
	logic [17:0] q[$];                      // notes: flag, irq, lower, upper
	logic [7:0]  lt[4][2] = '{'{8'h10, 8'h20}, '{8'h20, 8'h10}, '{8'hFF, 8'h10}, '{8'h10, 8'h10}};
	initial forever #50 sys_clk = ~sys_clk;
	conv_model i_conv (.sys_clk(sys_clk), .result_valid(rv), .conversion_result(res));
	adc_window_detector i_dut (.sys_clk(sys_clk), .rstn(rstn), .result_valid(rv), .conversion_result(res),
		.differential_mode(dm), .lower_limit_we(lwe), .upper_limit_we(uwe), .limit_wdata(wd),
		.flag_clear(clr), .irq_enable(en), .window_lower_limit(lo_o), .window_upper_limit(hi_o),
		.window_match_flag(flag), .irq(irq));
	// reference window test, inside form when upper is above lower
	function logic hit(logic d, logic [7:0] lw, hg, rs);
		int a, b, x;
		a = lw; b = hg; x = rs;
		if (d) begin
			a = $signed(lw); b = $signed(hg); x = $signed(rs);
		end
		return (b > a) ? (x > a && x < b) : (x < b || x > a);
	endfunction
	task step; @(posedge sys_clk); #1; endtask
	task results;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// watcher: one note is due after every taken result
	always @(posedge sys_clk) if (rv === 1'b1) begin
		#2;
		if (q.size() == 0) `CHK(1'b1, 1'b0)
		else `CHK({flag, irq, lo_o, hi_o}, q.pop_front())
	end
	initial begin
		void'($urandom(32'h8d56));
		repeat (10) @(posedge sys_clk);
		#1 rstn = 1;
		`CHK({flag, irq, lo_o, hi_o}, 18'h0)
		for (int i = 0; i < 300; i++) begin
			k = i % 5;
			l = (k < 4) ? lt[k][0] : 8'($urandom);
			h = (k < 4) ? lt[k][1] : 8'($urandom);
			r = i[1] ? 8'((i[0] ? l : h) + $urandom_range(2) - 1) : 8'($urandom);
			wd = l; lwe = 1; step; lwe = 0;
			wd = h; uwe = 1; step; uwe = 0;
			dm = (k == 2) | 1'($urandom_range(1));
			clr = 1'($urandom_range(1));
			en = 1'($urandom_range(1));
			e = hit(dm, l, h, r) | (e & ~clr);
			q.push_back({e, e & en, l, h});
			i_conv.convert(r);
			clr = 0;
		end
		step;
		`CHK(q.size(), 0)
		results;
	end
endmodule
